// File: hdl/srlp_pkg.sv
// constants shared by the sensor register load port
// assumes one 250 MHz system clock; every pin arrives asynchronously
package srlp_pkg;

  localparam int unsigned BUS_W      = 10;
  localparam int unsigned SET_W      = 8;
  localparam int unsigned SEL_W      = 2;
  localparam int unsigned NUM_SET    = 4;
  localparam int unsigned ROUTE_W    = 6;
  localparam int unsigned CONV_W     = 10;
  localparam int unsigned CONV_DEPTH = 7;

  // settings register select codes, taken from the top two bus bits
  localparam logic [SEL_W-1:0] SEL_MODE_CONTROL = 2'h0;
  localparam logic [SEL_W-1:0] SEL_GAIN_STAGE   = 2'h1;
  localparam logic [SEL_W-1:0] SEL_BLACK_LEVEL  = 2'h2;
  localparam logic [SEL_W-1:0] SEL_OFFSET_TRIM  = 2'h3;

  localparam logic [BUS_W-1:0] START_RESET = 10'h000;
  localparam logic [SET_W-1:0] SET_RESET   = 8'h00;

  // bus field positions
  localparam int unsigned SEL_LSB  = 8;
  localparam int unsigned DATA_MSB = 7;

  // mode_control fields
  localparam int unsigned MC_SCAN_MSB  = 6;
  localparam int unsigned MC_SCAN_LSB  = 5;
  localparam int unsigned MC_ROUTE_MSB = 4;
  localparam int unsigned MC_ROUTE_LSB = 2;
  localparam int unsigned MC_NDR_BIT   = 1;
  localparam int unsigned MC_STBY_BIT  = 0;

  // gain_stage_setting fields
  localparam int unsigned GS_OFS_MSB  = 7;
  localparam int unsigned GS_OFS_LSB  = 2;
  localparam int unsigned GS_GAIN_MSB = 1;
  localparam int unsigned GS_GAIN_LSB = 0;

  // scan-end source codes
  localparam logic [1:0] SCAN_LINE_READ  = 2'h0;
  localparam logic [1:0] SCAN_LINE_RESET = 2'h1;

  // output selector codes and one-hot route positions
  localparam logic [2:0] ROUTE_PIXEL   = 3'h0;
  localparam logic [2:0] ROUTE_THERMAL = 3'h1;
  localparam logic [2:0] ROUTE_AUX1    = 3'h4;
  localparam int unsigned RT_PIXEL   = 0;
  localparam int unsigned RT_THERMAL = 1;
  localparam int unsigned RT_AUX1    = 2;

endpackage

// File: hdl/srlp_top.sv
// sensor register load port: start latches, settings registers, output chain
// assumes strobes and bus are asynchronous pins held >= 100 ns and converter clock levels held 52 ns,
// so two-flop sampling at 250 MHz sees every level and edge
//
// How it works
// RL1: ten-bit bus, three separate load strobes
// RL2: line/column strobe loads all ten bits
// RL3: start latches follow bus while strobe high
// RL4: setting strobe edge: top bits select register
// RL5: settings capture on strobe rise, else hold
// RL6: clear-low zeroes all four settings registers
// RL7: mode_control field layout as specified
// RL8: select three holds column offset trim
// RL9: selector codes route pixel, thermal, aux
// RL10: start line seeds read and reset pointers
// RL11: start column seeds column pointer, default zero
// RL12: controller keeps start line within 0..1023
// RL13: controller pulses calibration after gain changes
// RL14: calibration preferably mirrors line-gap strobe
// RL15: line-gap strobe resets column pointer
// RL16: controller halts column clock for gain change
// RL17: calibration pulse 200 ns, line gap idle
// RL18: wait 50 ns, restart column clock
// RL19: converter samples rising, updates falling edge
// RL20: converter output exactly 6.5 cycles later
// RL21: selected signal buffered to analog pad
// RL22: scan-end select routes pointer last stage
// RL23: gain code and 64-step offset field
// RL24: low power disables bias, gain, buffer
`timescale 1ns/1ps
module srlp_top
  import srlp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [BUS_W-1:0]  load_bus_i,
  input  wire logic              line_start_strobe_i,
  input  wire logic              column_start_strobe_i,
  input  wire logic              setting_write_strobe_i,
  input  wire logic              setting_clear_n_i,
  input  wire logic              line_gap_strobe_i,
  input  wire logic              gain_stage_cal_i,
  input  wire logic              line_read_last_i,
  input  wire logic              line_reset_last_i,
  input  wire logic              column_read_last_i,
  input  wire logic              conv_clk_i,
  input  wire logic [CONV_W-1:0] conv_sample_i,
  output logic [BUS_W-1:0]       start_line_o,
  output logic [BUS_W-1:0]       start_column_o,
  output logic [SET_W-1:0]       mode_control_o,
  output logic [SET_W-1:0]       gain_stage_setting_o,
  output logic [SET_W-1:0]       nondestructive_black_level_o,
  output logic [SET_W-1:0]       column_bus_offset_trim_o,
  output logic [ROUTE_W-1:0]     analog_route_o,
  output logic                   analog_pad_enable_o,
  output logic                   low_power_o,
  output logic                   nondestructive_readout_o,
  output logic                   scan_end_flag_o,
  output logic                   column_pointer_reset_o,
  output logic                   gain_stage_cal_o,
  output logic [CONV_W-1:0]      conv_data_o
);

  // ------------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------------
  // ten single-bit pins ride alongside the bus and the converter word
  localparam int unsigned PIN_W = BUS_W + 10 + CONV_W;

  logic [1:0]       rst_q;
  logic             rst_n;
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // multi-bit bus is safe to sample: it is settled 100 ns before any strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_q      <= '0;
    end else begin
      pin_meta_q <= {conv_sample_i, conv_clk_i, column_read_last_i, line_reset_last_i,
                     line_read_last_i, gain_stage_cal_i, line_gap_strobe_i,
                     setting_clear_n_i, setting_write_strobe_i, column_start_strobe_i,
                     line_start_strobe_i, load_bus_i};
      pin_q      <= pin_meta_q;
    end
  end

  logic [BUS_W-1:0]  bus_s;
  logic              line_stb_s;
  logic              col_stb_s;
  logic              wr_stb_s;
  logic              clr_n_s;
  logic              gap_s;
  logic              cal_s;
  logic [2:0]        last_s;
  logic              cclk_s;
  logic [CONV_W-1:0] csample_s;

  // RL1: bus and strobes
  assign {csample_s, cclk_s, last_s, cal_s, gap_s, clr_n_s, wr_stb_s, col_stb_s,
          line_stb_s, bus_s} = pin_q;

  // ------------------------------------------------------------------
  // start latches and settings registers
  // ------------------------------------------------------------------
  logic [BUS_W-1:0] line_q, line_d, col_q, col_d;
  logic [SET_W-1:0] set_q [NUM_SET];
  logic [SET_W-1:0] set_d [NUM_SET];
  logic             wr_prev_q, wr_prev_d;
  logic             wr_rise;
  logic [SEL_W-1:0] sel;

  assign wr_rise = wr_stb_s && !wr_prev_q;
  assign sel     = bus_s[BUS_W-1:SEL_LSB];

  always_comb begin
    // RL2: strobe loads all ten bits
    // RL3: transparent while high, frozen on fall
    line_d    = line_stb_s ? bus_s : line_q;
    col_d     = col_stb_s ? bus_s : col_q;
    wr_prev_d = wr_stb_s;
    for (int i = 0; i < NUM_SET; i++) begin
      // RL6: clear zeroes settings
      if (!clr_n_s) begin
        set_d[i] = SET_RESET;
      // RL4: select decode, low byte write
      // RL5: capture on rising edge only
      end else if (wr_rise && sel == SEL_W'(i)) begin
        set_d[i] = bus_s[DATA_MSB:0];
      end else begin
        set_d[i] = set_q[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      line_q    <= START_RESET;
      col_q     <= START_RESET;
      wr_prev_q <= 1'b0;
      for (int i = 0; i < NUM_SET; i++) begin
        set_q[i] <= SET_RESET;
      end
    end else begin
      line_q    <= line_d;
      col_q     <= col_d;
      wr_prev_q <= wr_prev_d;
      for (int i = 0; i < NUM_SET; i++) begin
        set_q[i] <= set_d[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // output chain controls
  // ------------------------------------------------------------------
  logic [SET_W-1:0]   mode;
  logic [2:0]         route_code;
  logic [ROUTE_W-1:0] route_d, route_q;
  logic               scan_d, scan_q;
  logic               gap_q, cal_q;
  logic               pad_en_d, pad_en_q;

  assign mode       = set_q[SEL_MODE_CONTROL];
  assign route_code = mode[MC_ROUTE_MSB:MC_ROUTE_LSB];

  always_comb begin
    // RL9: one-hot route; codes 010 and 011 select nothing
    route_d = '0;
    if (route_code == ROUTE_PIXEL) begin
      route_d[RT_PIXEL] = 1'b1;
    end else if (route_code == ROUTE_THERMAL) begin
      route_d[RT_THERMAL] = 1'b1;
    end else if (route_code >= ROUTE_AUX1) begin
      route_d[RT_AUX1 + 32'(route_code - ROUTE_AUX1)] = 1'b1;
    end
    // RL22: scan-end source select
    unique case (mode[MC_SCAN_MSB:MC_SCAN_LSB])
      SCAN_LINE_READ:  scan_d = last_s[0];
      SCAN_LINE_RESET: scan_d = last_s[1];
      default:         scan_d = last_s[2];
    endcase
    // RL21: pad buffer on unless standby
    pad_en_d = !mode[MC_STBY_BIT];
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= '0;
      scan_q  <= 1'b0;
      gap_q   <= 1'b0;
      cal_q   <= 1'b0;
      // buffer is on while the settings sit at their zero reset value
      pad_en_q <= 1'b1;
    end else begin
      route_q <= route_d;
      scan_q  <= scan_d;
      gap_q   <= gap_s;
      cal_q   <= cal_s;
      pad_en_q <= pad_en_d;
    end
  end

  // ------------------------------------------------------------------
  // converter pipeline: shift on rising edge, present on falling edge
  // ------------------------------------------------------------------
  logic [CONV_W-1:0] pipe_q [CONV_DEPTH];
  logic [CONV_W-1:0] pipe_d [CONV_DEPTH];
  logic [CONV_W-1:0] cdata_q, cdata_d;
  logic              cclk_prev_q, cclk_prev_d;
  logic              c_rise, c_fall;

  assign c_rise = cclk_s && !cclk_prev_q;
  assign c_fall = !cclk_s && cclk_prev_q;

  always_comb begin
    cclk_prev_d = cclk_s;
    // RL19: sample on rising edge
    for (int i = 0; i < CONV_DEPTH; i++) begin
      if (c_rise) begin
        pipe_d[i] = (i == 0) ? csample_s : pipe_q[(i == 0) ? 0 : i-1];
      end else begin
        pipe_d[i] = pipe_q[i];
      end
    end
    // RL20: seventh stage read at falling edge gives 6.5 cycles
    cdata_d = c_fall ? pipe_q[CONV_DEPTH-1] : cdata_q;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cclk_prev_q <= 1'b0;
      cdata_q     <= '0;
      for (int i = 0; i < CONV_DEPTH; i++) begin
        pipe_q[i] <= '0;
      end
    end else begin
      cclk_prev_q <= cclk_prev_d;
      cdata_q     <= cdata_d;
      for (int i = 0; i < CONV_DEPTH; i++) begin
        pipe_q[i] <= pipe_d[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // RL10: one start line seeds both line pointers
  // RL11: start column seeds column pointer
  assign start_line_o                 = line_q;
  assign start_column_o               = col_q;
  // RL7: mode_control fields
  assign mode_control_o               = set_q[SEL_MODE_CONTROL];
  // RL23: gain and offset fields
  assign gain_stage_setting_o         = set_q[SEL_GAIN_STAGE];
  assign nondestructive_black_level_o = set_q[SEL_BLACK_LEVEL];
  // RL8: offset trim register
  assign column_bus_offset_trim_o     = set_q[SEL_OFFSET_TRIM];
  assign analog_route_o               = route_q;
  // RL21: pad buffer on unless standby
  // RL24: standby disables the pad buffer and raises low_power_o
  assign analog_pad_enable_o          = pad_en_q;
  assign low_power_o                  = mode[MC_STBY_BIT];
  assign nondestructive_readout_o     = mode[MC_NDR_BIT];
  assign scan_end_flag_o              = scan_q;
  // RL15: line gap clears column pointer
  assign column_pointer_reset_o       = gap_q;
  // RL13: calibration strobe passed to gain stage
  assign gain_stage_cal_o             = cal_q;
  assign conv_data_o                  = cdata_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence wr_clean_s;
    wr_rise && clr_n_s;
  endsequence

  line_follow_a: assert property (line_stb_s |=> start_line_o == $past(bus_s)) // RL3
    else $error("start line does not follow bus");
  line_freeze_a: assert property (!line_stb_s ##1 !line_stb_s |-> $stable(start_line_o)) // RL3
    else $error("start line changed while strobe low");
  col_follow_a: assert property (col_stb_s |=> start_column_o == $past(bus_s)) // RL2
    else $error("start column does not follow bus");
  mode_write_a: assert property (wr_clean_s and sel == SEL_MODE_CONTROL
                                 |=> mode_control_o == $past(bus_s[DATA_MSB:0])) // RL4
    else $error("mode_control not written");
  trim_hold_a: assert property (!(wr_rise && clr_n_s && sel == SEL_OFFSET_TRIM) && clr_n_s
                                |=> $stable(column_bus_offset_trim_o)) // RL5
    else $error("offset trim changed without write");
  clear_all_a: assert property (!clr_n_s |=> mode_control_o == '0 && gain_stage_setting_o == '0
                                && nondestructive_black_level_o == '0
                                && column_bus_offset_trim_o == '0) // RL6
    else $error("settings not cleared");
  route_pixel_a: assert property (route_code == ROUTE_PIXEL && $stable(route_code)
                                  |=> analog_route_o[RT_PIXEL] && $onehot(analog_route_o)) // RL9
    else $error("pixel route wrong");
  route_none_a: assert property (route_code[2:1] == 2'h1 |=> analog_route_o == '0) // RL9
    else $error("unused selector code routed");
  scan_reset_a: assert property (mode[MC_SCAN_MSB:MC_SCAN_LSB] == SCAN_LINE_RESET
                                 |=> scan_end_flag_o == $past(last_s[1])) // RL22
    else $error("scan-end source wrong");
  gap_reset_a: assert property ($rose(gap_s) |=> column_pointer_reset_o) // RL15
    else $error("line gap did not reset column pointer");
  conv_edge_a: assert property (c_fall |=> conv_data_o == $past(pipe_q[CONV_DEPTH-1])) // RL20
    else $error("converter output not updated on falling edge");
  conv_hold_a: assert property (!c_fall |=> $stable(conv_data_o)) // RL19
    else $error("converter output moved off falling edge");

endmodule // srlp_top

// File: tb/srlp_conv_model.sv
// converter-side partner: clock pin and sample words for the on-chip converter
// assumes a 250 MHz bench clock and a synchronous run level from the bench
`timescale 1ns/1ps
module srlp_conv_model
  import srlp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              run_i,
  output logic                   conv_clk_o,
  output logic [CONV_W-1:0]      conv_sample_o
);
  logic [3:0] phase_q;

  initial begin
    conv_clk_o    = 1'b0;
    conv_sample_o = 10'h011;
    phase_q       = 4'h0;
  end

  // --------------------------------------------------------------
  // clock and word stream
  // --------------------------------------------------------------
  // steady stream
  // 13 clk per half gives 104 ns with an exact 50 percent duty
  always @(posedge clk_i) begin
    if (run_i) begin
      if (phase_q == 4'hc) begin
        phase_q    <= 4'h0;
        conv_clk_o <= ~conv_clk_o;
        // new word right after the fall, long before the next sampling rise
        if (conv_clk_o) begin
          conv_sample_o <= conv_sample_o * 10'h00d + 10'h025;
        end
      end else begin
        phase_q <= phase_q + 4'h1;
      end
    end
  end
endmodule // srlp_conv_model

// File: tb/srlp_top_tb_top.sv
// self-checking bench for the sensor register load port
// assumes the design samples every pin through two flops at 250 MHz
`timescale 1ns/1ps
module srlp_top_tb_top;
  import srlp_pkg::*;
  logic              clk = 1'b0, rst_b = 1'b0, clear_n = 1'b1, gap = 1'b0, cal = 1'b0;
  logic              ld_line = 1'b0, ld_col = 1'b0, ld_set = 1'b0;
  logic              rd_last = 1'b0, rst_last = 1'b0, col_last = 1'b0, conv_clk, cprev = 1'b0;
  logic [BUS_W-1:0]  bus = 10'h000, start_line, start_col;
  logic [SET_W-1:0]  mode, gain, blk, trim;
  logic [ROUTE_W-1:0] route;
  logic              pad_en, low_pwr, ndr_o, scan_end, col_rst, cal_o;
  logic [CONV_W-1:0] conv_sample, conv_data, want, hist[$];
  int                fails = 0, tests_run = 0, cycles = 0, due = 0;

  always #2 clk = ~clk;

  srlp_conv_model conv (.clk_i(clk), .run_i(rst_b), .conv_clk_o(conv_clk),
                        .conv_sample_o(conv_sample));

  srlp_top uut (
    .clk_i(clk), .rst_b_i(rst_b), .load_bus_i(bus), .line_start_strobe_i(ld_line),
    .column_start_strobe_i(ld_col), .setting_write_strobe_i(ld_set),
    .setting_clear_n_i(clear_n), .line_gap_strobe_i(gap), .gain_stage_cal_i(cal),
    .line_read_last_i(rd_last), .line_reset_last_i(rst_last), .column_read_last_i(col_last),
    .conv_clk_i(conv_clk), .conv_sample_i(conv_sample), .start_line_o(start_line),
    .start_column_o(start_col), .mode_control_o(mode), .gain_stage_setting_o(gain),
    .nondestructive_black_level_o(blk), .column_bus_offset_trim_o(trim),
    .analog_route_o(route), .analog_pad_enable_o(pad_en), .low_power_o(low_pwr),
    .nondestructive_readout_o(ndr_o), .scan_end_flag_o(scan_end),
    .column_pointer_reset_o(col_rst), .gain_stage_cal_o(cal_o), .conv_data_o(conv_data));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [BUS_W-1:0] seen, input logic [BUS_W-1:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // strobe cycle: 100 ns setup, width and hold, then the bus is driven to its complement
  task automatic pulse(input int which, input logic [BUS_W-1:0] val);
    bus <= val;
    wclk(25);
    if (which == 0) ld_line <= 1'b1;
    else if (which == 1) ld_col <= 1'b1;
    else ld_set <= 1'b1;
    wclk(25);
    ld_line <= 1'b0;
    ld_col  <= 1'b0;
    ld_set  <= 1'b0;
    wclk(25);
    bus <= ~val;
    // let an edge pass so a following call never drives the bus twice in one step
    wclk(1);
  endtask

  function automatic logic [ROUTE_W-1:0] route_of(input logic [2:0] c);
    if (c == 3'h0) return 6'h01;
    if (c == 3'h1) return 6'h02;
    if (c[2]) return 6'h04 << c[1:0];
    return 6'h00;
  endfunction

  // converter words come out at the 7th fall after their sampling rise
  always @(posedge clk) begin
    cprev <= conv_clk;
    if (conv_clk && !cprev) hist.push_back(conv_sample);
    if (!conv_clk && cprev && hist.size() == 7) begin
      want = hist.pop_front();
      due  = 4;
    end else if (due > 0) begin
      due--;
      if (due == 0) check(conv_data, want, "converter word");
    end
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    wclk(2);
    rst_b <= 1'b1;
    wclk(8);
    check(mode, 8'h00, "mode after reset");
    check(trim, 8'h00, "trim after reset");
    check(start_col, 10'h000, "column start after reset");
    check(route, 6'h01, "route after reset");
    pulse(2, {SEL_GAIN_STAGE, 8'hc6});
    pulse(2, {SEL_BLACK_LEVEL, 8'h81});
    pulse(2, {SEL_OFFSET_TRIM, 8'h5e});
    check(gain, 8'hc6, "gain setting");
    check(blk, 8'h81, "black level");
    check(trim, 8'h5e, "offset trim");
    for (int c = 0; c < 8; c++) begin
      rd_last  <= c[2];
      rst_last <= !c[2];
      col_last <= !c[0];
      pulse(2, {SEL_MODE_CONTROL, 1'b0, c[1:0], c[2:0], c[2], c[0]});
      check(mode, {1'b0, c[1:0], c[2:0], c[2], c[0]}, "mode value");
      check(route, route_of(c[2:0]), "route");
      check(pad_en, !c[0], "pad enable");
      check(low_pwr, c[0], "low power");
      check(ndr_o, c[2], "readout style");
      check(scan_end, c[1:0] == 0 ? c[2] : c[1:0] == 1 ? !c[2] : !c[0], "scan end");
    end
    check(gain, 8'hc6, "gain held");
    bus <= 10'h3ff;
    wclk(25);
    ld_line <= 1'b1;
    wclk(5);
    check(start_line, 10'h3ff, "last line");
    bus <= 10'h155;
    wclk(5);
    check(start_line, 10'h155, "line latch open");
    wclk(20);
    ld_line <= 1'b0;
    wclk(25);
    bus <= 10'h0aa;
    wclk(5);
    check(start_line, 10'h155, "line latch frozen");
    pulse(1, 10'h2aa);
    check(start_col, 10'h2aa, "column start");
    clear_n <= 1'b0;
    wclk(5);
    check(gain, 8'h00, "cleared gain");
    check(blk, 8'h00, "cleared black level");
    pulse(2, {SEL_OFFSET_TRIM, 8'h33});
    check(trim, 8'h00, "write under clear");
    clear_n <= 1'b1;
    wclk(5);
    check(start_line, 10'h155, "line kept over clear");
    check(start_col, 10'h2aa, "column kept over clear");
    gap <= 1'b1;
    wclk(4);
    check(col_rst, 1'b1, "column pointer reset");
    gap <= 1'b0;
    pulse(2, {SEL_GAIN_STAGE, 8'h03});
    check(col_rst, 1'b0, "column pointer reset idle");
    // calibration after the gain change: 200 ns high, line gap idle, then 52 ns
    // no column clock reaches this block, so it stands halted throughout
    // gap stays idle here, mid-line change overrides the shared waveform
    cal <= 1'b1;
    wclk(4);
    check(cal_o, 1'b1, "calibration high");
    wclk(46);
    cal <= 1'b0;
    wclk(13);
    check(cal_o, 1'b0, "calibration low");
    check(gain, 8'h03, "new gain");
    wclk(400);
    stop_test();
  end
endmodule // srlp_top_tb_top
